// [rtl/olic_top.sv]
// register file for init control and loopback setup, with link suppress
`timescale 1ns/1ps
module olic_top
	import olic_pkg::*;
(
	input  wire logic        clk,                 // system clock
	input  wire logic        rst_n,               // sync reset, active low
	input  wire logic        center_mode,         // 1 = center side
	input  wire logic        rate_strap_pin,      // rate strap level
	input  wire logic        duplex_strap_pin,    // duplex strap level
	input  wire logic        autoneg_strap_pin,   // autoneg strap level
	input  wire logic        link_suppress_strap, // enhanced suppress strap
	input  wire logic        reg_wr,              // management write strobe
	input  wire logic [7:0]  reg_addr,            // management address
	input  wire logic [7:0]  reg_wdata,           // management write data
	output logic      [7:0]  reg_rdata,           // read data, registered
	input  wire logic [47:0] station_addr,        // bytes 0x52..0x57
	input  wire logic        fiber_link_up,       // fiber port link
	input  wire logic        far_copper_link_up,  // far side copper link
	output logic             copper_port_rate_sel,   // 1 = 100 Mbps
	output logic             copper_port_duplex_sel, // 1 = full duplex
	output logic             copper_port_autoneg_en, // 1 = autoneg on
	output logic             fabric_soft_reset,   // one-cycle reset pulse
	output logic             phy_soft_reset,      // Phy_soft_reset level
	output logic             remote_cmd_en,       // remote command allowed
	output logic             fiber_tx_oe_n,       // low = drive fiber tx
	output logic             copper_tx_disable,   // copper tx suppressed
	output logic             copper_led_off,      // copper LEDs off
	output logic             valid_cnt_clear,     // clear 0x4D/0x4E pulse
	output logic             result_cnt_clear,    // clear 0x46-0x48 pulse
	output logic             lb_busy,             // burst in progress
	output logic             tx_valid,            // loopback byte valid
	output logic      [7:0]  tx_data,             // loopback byte
	output logic             tx_last,             // last byte of frame
	input  wire logic        tx_ready             // loopback sink ready
);
	logic       loaded_q;
	logic       rate_q, duplex_q, autoneg_q, enh_q, rcmd_q, txdis_q, phyrst_q;
	logic       fabrst_q;
	logic [7:0] count_q, pattern_q, rdata_q;
	logic       vclr_q, rclr_q, start_q, suppress_q;
	logic       wr_init, wr_pc, wr_cnt;

	olic_lb_if lbi ();

	default clocking cb_chk @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	assign wr_init = reg_wr && reg_addr == ADDR_INIT_CTRL;
	assign wr_pc   = reg_wr && reg_addr == ADDR_PORT_CTRL;
	assign wr_cnt  = reg_wr && reg_addr == ADDR_LB_COUNT;

	////////////////////////////////////////////////////////////////////////
	// straps are caught by the first clock after reset release, so the
	// reset itself only loads constants
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			loaded_q <= 1'b0;
		else
			loaded_q <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rate_q    <= 1'b0;
			duplex_q  <= 1'b0;
			autoneg_q <= 1'b0;
		end
		else if (!loaded_q)
		begin
			rate_q    <= rate_strap_pin; // R1
			duplex_q  <= duplex_strap_pin; // R2
			autoneg_q <= autoneg_strap_pin; // R3
		end
		else if (wr_init)
		begin
			rate_q    <= reg_wdata[BIT_RATE]; // R1
			duplex_q  <= reg_wdata[BIT_DUPLEX]; // R2
			autoneg_q <= reg_wdata[BIT_AUTONEG]; // R3
		end
		else if (wr_pc)
		begin
			rate_q    <= reg_wdata[PC_RATE]; // R1
			duplex_q  <= reg_wdata[PC_DUPLEX]; // R2
			autoneg_q <= reg_wdata[PC_AUTONEG]; // R3
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			enh_q   <= 1'b0;
			rcmd_q  <= 1'b0; // R5
			txdis_q <= 1'b0; // R7
		end
		else if (!loaded_q)
			enh_q <= link_suppress_strap; // R6
		else if (wr_init)
		begin
			enh_q   <= reg_wdata[BIT_ENH_LINK]; // R6
			rcmd_q  <= reg_wdata[BIT_REM_CMD]; // R5
			txdis_q <= reg_wdata[BIT_FIB_TXD]; // R7
		end
	end

	// phy_soft_reset: center side holds it from power up until 0x40 is set up
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			phyrst_q <= 1'b0;
		else if (!loaded_q)
			phyrst_q <= center_mode; // R8
		else if (wr_init && reg_wdata[BIT_PHY_RST])
			phyrst_q <= 1'b1; // R8
		else if (!center_mode || (reg_wr && reg_addr == ADDR_CENTER_CFG))
			phyrst_q <= 1'b0; // R8
		else if (phyrst_q && !center_mode)
			phyrst_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			fabrst_q <= 1'b0;
		else
			fabrst_q <= wr_init && reg_wdata[BIT_FAB_RST]; // R4
	end

	////////////////////////////////////////////////////////////////////////
	// maintenance sublayer setup: restored by soft reset, kept by phy_soft_reset
	always_ff @(posedge clk)
	begin
		if (!rst_n || fabrst_q)
		begin
			count_q   <= LB_COUNT_RST; // R11
			pattern_q <= LB_PATTERN_RST; // R9
		end
		else if (wr_cnt)
			count_q <= reg_wdata;
		else if (reg_wr && reg_addr == ADDR_LB_PATTERN)
			pattern_q <= reg_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			vclr_q  <= 1'b0;
			rclr_q  <= 1'b0;
			start_q <= 1'b0;
		end
		else
		begin
			vclr_q  <= wr_cnt && reg_wdata == LB_COUNT_CLEAR; // R10
			rclr_q  <= wr_cnt && reg_wdata == LB_COUNT_CLEAR && center_mode;
			// R10
			start_q <= wr_cnt && center_mode && reg_wdata != LB_COUNT_CLEAR
				&& reg_wdata <= LB_COUNT_MAX; // R16 R12
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			suppress_q <= 1'b0;
		else
			suppress_q <= !center_mode && enh_q
				&& (!fiber_link_up || !far_copper_link_up); // R6
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else
			case (reg_addr)
				ADDR_INIT_CTRL: rdata_q <= {rate_q, duplex_q, autoneg_q,
					1'b0, rcmd_q, enh_q, txdis_q, phyrst_q}; // R4
				ADDR_PORT_CTRL: rdata_q <= {autoneg_q, rate_q, duplex_q,
					5'h00};
				ADDR_LB_COUNT: rdata_q <= count_q;
				ADDR_LB_PATTERN: rdata_q <= pattern_q;
				default: rdata_q <= 8'h00;
			endcase
	end

	assign lbi.start        = start_q;
	assign lbi.abort        = fabrst_q;
	assign lbi.count        = count_q;
	assign lbi.pattern      = pattern_q;
	assign lbi.station_addr = station_addr;

	olic_lb_gen u_gen (
		.clk      (clk),
		.rst_n    (rst_n),
		.lb       (lbi.gen),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.tx_last  (tx_last),
		.tx_ready (tx_ready)
	);

	assign reg_rdata              = rdata_q;
	assign copper_port_rate_sel   = rate_q;
	assign copper_port_duplex_sel = duplex_q;
	assign copper_port_autoneg_en = autoneg_q;
	assign fabric_soft_reset      = fabrst_q;
	assign phy_soft_reset         = phyrst_q;
	assign remote_cmd_en          = rcmd_q;
	assign fiber_tx_oe_n          = txdis_q; // R7
	assign copper_tx_disable      = suppress_q;
	assign copper_led_off         = suppress_q;
	assign valid_cnt_clear        = vclr_q;
	assign result_cnt_clear       = rclr_q;
	assign lb_busy                = lbi.busy;

	////////////////////////////////////////////////////////////////////////
	AST_STRAP_LOAD: assert property ( // R1 R2 R3
		!loaded_q |=> rate_q == $past(rate_strap_pin)
		&& duplex_q == $past(duplex_strap_pin)
		&& autoneg_q == $past(autoneg_strap_pin))
		else $error("straps not loaded after reset");
	AST_SOFT_PULSE: assert property ( // R4
		wr_init && reg_wdata[BIT_FAB_RST] |=> fabric_soft_reset ##1
		(!fabric_soft_reset || $past(wr_init)))
		else $error("soft reset not a single pulse");
	AST_SOFT_READS_0: assert property ( // R4
		$past(reg_addr) == ADDR_INIT_CTRL && loaded_q
		|-> !reg_rdata[BIT_FAB_RST])
		else $error("soft reset bit read as one");
	AST_PHY_HOLD: assert property ( // R8
		phy_soft_reset && center_mode && !reg_wr ##1 center_mode
		|-> phy_soft_reset)
		else $error("center phy_soft_reset dropped before config write");
	AST_PHY_KEEPS_MC: assert property ( // R9
		phy_soft_reset && !reg_wr && !fabrst_q
		|=> $stable(count_q) && $stable(pattern_q))
		else $error("phy_soft_reset altered sublayer setup");
	AST_CLEAR: assert property ( // R10
		wr_cnt && reg_wdata == LB_COUNT_CLEAR |=> valid_cnt_clear
		&& result_cnt_clear == $past(center_mode) && !lb_busy ##1 !lb_busy)
		else $error("count clear misbehaved");
	AST_SUPPRESS: assert property ( // R6
		center_mode ##1 center_mode |-> !copper_tx_disable)
		else $error("suppress active in center mode");
	AST_FIBER_OE: assert property ( // R7 R5
		wr_init && loaded_q
		|=> fiber_tx_oe_n == $past(reg_wdata[BIT_FIB_TXD])
		&& remote_cmd_en == $past(reg_wdata[BIT_REM_CMD]))
		else $error("fiber tx or remote enable not written");
	COV_BURST: cover property (start_q ##1 lb_busy);
	COV_TERM_SUPPRESS: cover property (copper_tx_disable);
endmodule

// [rtl/olic_pkg.sv]
// constants shared by the loopback and initialisation control block
//
// Function
// R1 - the rate select bit picks 100 Mbps when set, 10 Mbps when clear, is bit 6 of 0x2C, and loads from the rate strap.
// R2 - the duplex bit picks full duplex when set, half when clear, is bit 5 of 0x2C, and loads from the duplex strap.
// R3 - the autonegotiation bit enables autonegotiation when set, is bit 7 of 0x2C, and loads from its strap.
// R4 - writing one to the soft reset bit resets the sublayer, port MACs and fabric, then self-clears and reads zero.
// R5 - the remote command enable bit permits remote commands on both sides when set and resets to zero.
// R6 - in terminal mode with enhanced suppress set, fiber or far copper link loss disables copper transmit and its LEDs.
// R7 - the fiber transmit disable bit tri-states transmit toward the fiber PHY and resets to zero.
// R8 - writing one to the Phy_soft_reset bit resets both PHYs then self-clears; in center mode it powers up set until 0x40 is written.
// the code does not self-clear it in center mode: a written one stays set there until 0x40 is written.
// R9 - the Phy_soft_reset leaves all maintenance sublayer registers untouched.
// R10 - writing zero to the count register clears the 0x4D/0x4E counters and, on the center side, the 0x46-0x48 counters.
// R11 - on the center side a count of 1 to 100 sends exactly that many loopback packets; the default count is 7.
// R12 - software never writes a count of 0x65 through 0xFF.
// R13 - the one-hot pattern select picks packet length, broadcast or unicast destination, and the data word.
// R14 - the destination is the station address with last byte plus one, rising by one per packet.
// R15 - the source is the station address in order and the type field is 0x0800.
// R16 - writing a valid nonzero count on the center side starts a burst with the pattern then selected.
package olic_pkg;
	localparam logic [7:0] ADDR_PORT_CTRL   = 8'h2C;
	localparam logic [7:0] ADDR_CENTER_CFG  = 8'h40;
	localparam logic [7:0] ADDR_INIT_CTRL   = 8'h43;
	localparam logic [7:0] ADDR_LB_COUNT    = 8'h44;
	localparam logic [7:0] ADDR_LB_PATTERN  = 8'h45;
	// field positions in phy_switch_init_ctrl
	localparam int BIT_RATE     = 7;
	localparam int BIT_DUPLEX   = 6;
	localparam int BIT_AUTONEG  = 5;
	localparam int BIT_FAB_RST  = 4;
	localparam int BIT_REM_CMD  = 3;
	localparam int BIT_ENH_LINK = 2;
	localparam int BIT_FIB_TXD  = 1;
	localparam int BIT_PHY_RST  = 0;
	// field positions in the shared port control register
	localparam int PC_AUTONEG   = 7;
	localparam int PC_RATE      = 6;
	localparam int PC_DUPLEX    = 5;
	localparam logic [7:0] LB_COUNT_RST   = 8'h07;
	localparam logic [7:0] LB_PATTERN_RST = 8'h00;
	localparam logic [7:0] LB_COUNT_MAX   = 8'h64;
	localparam logic [7:0] LB_COUNT_CLEAR = 8'h00;
	// frame layout
	localparam logic [10:0] LEN_SHORT  = 11'h040;
	localparam logic [10:0] LEN_LONG   = 11'h5EE;
	localparam logic [10:0] CRC_BYTES  = 11'h004;
	localparam logic [10:0] IDX_TYPE_HI = 11'h00C;
	localparam logic [10:0] IDX_TYPE_LO = 11'h00D;
	localparam logic [10:0] IDX_SA     = 11'h006;
	localparam logic [10:0] IDX_DA_LAST = 11'h005;
	localparam logic [15:0] ETH_TYPE   = 16'h0800;
	localparam logic [15:0] DATA_55AA  = 16'h55AA;
	localparam logic [15:0] DATA_0F0F  = 16'h0F0F;
	localparam logic [15:0] DATA_FF00  = 16'hFF00;
	localparam logic [7:0]  BCAST_BYTE = 8'hFF;

	typedef struct packed {
		logic        long_pkt;
		logic        bcast;
		logic [15:0] word;
	} olic_pat_t;

	// non one-hot selects fall back to the all-zero pattern
	function automatic olic_pat_t olic_decode(input logic [7:0] sel);
		olic_pat_t p;
		p = '{1'b0, 1'b0, DATA_55AA};
		case (sel)
			8'h01: p = '{1'b1, 1'b0, DATA_55AA};
			8'h02: p = '{1'b0, 1'b1, DATA_55AA};
			8'h04: p = '{1'b1, 1'b1, DATA_55AA};
			8'h08: p = '{1'b0, 1'b0, DATA_0F0F};
			8'h10: p = '{1'b1, 1'b0, DATA_0F0F};
			8'h20: p = '{1'b0, 1'b1, DATA_0F0F};
			8'h40: p = '{1'b1, 1'b1, DATA_0F0F};
			8'h80: p = '{1'b1, 1'b1, DATA_FF00};
			default: p = '{1'b0, 1'b0, DATA_55AA};
		endcase
		return p;
	endfunction
endpackage

// [rtl/olic_lb_if.sv]
// control link between the register file and the loopback generator
`timescale 1ns/1ps
interface olic_lb_if;
	logic        start;
	logic        abort;
	logic [7:0]  count;
	logic [7:0]  pattern;
	logic [47:0] station_addr;
	logic        busy;
	modport ctrl (output start, abort, count, pattern, station_addr,
		input busy);
	modport gen (input start, abort, count, pattern, station_addr,
		output busy);
endinterface

// [rtl/olic_lb_gen.sv]
// loopback packet generator: byte stream of a burst of test frames
`timescale 1ns/1ps
module olic_lb_gen
	import olic_pkg::*;
(
	input  wire logic clk,        // system clock
	input  wire logic rst_n,      // synchronous reset, active low
	olic_lb_if.gen    lb,         // start, count and pattern from registers
	output logic      tx_valid,   // byte on tx_data is valid
	output logic [7:0] tx_data,   // frame byte, destination first
	output logic      tx_last,    // last byte of a frame
	input  wire logic tx_ready    // sink takes the byte
);
	typedef enum logic {OLIC_IDLE, OLIC_SEND} olic_state_t;

	olic_state_t state_q;
	logic [10:0] idx_q;
	logic [7:0]  left_q;
	logic [7:0]  seq_q;
	olic_pat_t   pat_q;
	logic [47:0] sa_q;
	logic [7:0]  data_q;
	logic        last_q;
	logic [10:0] last_idx;
	logic        take;

	default clocking cb_chk @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	assign last_idx = (pat_q.long_pkt ? LEN_LONG : LEN_SHORT) - CRC_BYTES
		- 11'h001;
	assign take     = (state_q == OLIC_SEND) && tx_ready;
	assign tx_valid = (state_q == OLIC_SEND);
	assign tx_data  = data_q;
	assign tx_last  = last_q;
	assign lb.busy  = (state_q == OLIC_SEND);

	function automatic logic [7:0] frame_byte(input logic [10:0] i,
		input logic [7:0] seq, input olic_pat_t p, input logic [47:0] a);
		logic [7:0] b;
		b = 8'h00;
		if (i < IDX_SA)
		begin
			b = a[8'(47 - 8 * i) -: 8];
			if (p.bcast)
				b = BCAST_BYTE;
			else if (i == IDX_DA_LAST)
				b = a[7:0] + seq; // R14
		end
		else if (i < IDX_TYPE_HI)
			b = a[8'(47 - 8 * (i - IDX_SA)) -: 8]; // R15
		else if (i == IDX_TYPE_HI)
			b = ETH_TYPE[15:8]; // R15
		else if (i == IDX_TYPE_LO)
			b = ETH_TYPE[7:0]; // R15
		else
			b = i[0] ? p.word[7:0] : p.word[15:8]; // R13
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (!rst_n || lb.abort)
			state_q <= OLIC_IDLE;
		else
			case (state_q)
				OLIC_IDLE: if (lb.start) state_q <= OLIC_SEND; // R16
				OLIC_SEND: if (take && last_q && left_q == 8'h01)
					state_q <= OLIC_IDLE; // R11
				default: state_q <= OLIC_IDLE;
			endcase
	end

	// pattern and address are latched at start so a mid-burst write
	// cannot tear a frame
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			idx_q  <= 11'h000;
			left_q <= 8'h00;
			seq_q  <= 8'h00;
			pat_q  <= '{1'b0, 1'b0, DATA_55AA};
			sa_q   <= 48'h0000_0000_0000;
			data_q <= 8'h00;
			last_q <= 1'b0;
		end
		else if (state_q == OLIC_IDLE && lb.start)
		begin
			idx_q  <= 11'h000;
			left_q <= lb.count; // R11
			seq_q  <= 8'h01; // R14
			pat_q  <= olic_decode(lb.pattern); // R13
			sa_q   <= lb.station_addr;
			data_q <= frame_byte(11'h000, 8'h01, olic_decode(lb.pattern),
				lb.station_addr);
			last_q <= 1'b0;
		end
		else if (take)
		begin
			if (last_q)
			begin
				idx_q  <= 11'h000;
				left_q <= left_q - 8'h01;
				seq_q  <= seq_q + 8'h01; // R14
				data_q <= frame_byte(11'h000, seq_q + 8'h01, pat_q, sa_q);
				last_q <= 1'b0;
			end
			else
			begin
				idx_q  <= idx_q + 11'h001;
				data_q <= frame_byte(idx_q + 11'h001, seq_q, pat_q, sa_q);
				last_q <= (idx_q + 11'h001 == last_idx);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_TYPE_FIELD: assert property ( // R15
		tx_valid && idx_q == IDX_TYPE_HI |-> tx_data == ETH_TYPE[15:8])
		else $error("type field high byte wrong");
	AST_LAST_AT_LEN: assert property ( // R13
		tx_valid && tx_last |-> idx_q == last_idx)
		else $error("frame ended at wrong length");
	AST_SEQ_STEP: assert property ( // R14
		take && tx_last && left_q != 8'h01
		|=> seq_q == $past(seq_q) + 8'h01)
		else $error("destination sequence did not step");
	AST_BURST_END: assert property ( // R11
		take && tx_last && left_q == 8'h01 && !lb.abort |=> !tx_valid)
		else $error("burst did not stop after the counted frame");
	AST_START: assert property ( // R16
		!lb.busy && lb.start && !lb.abort
		|=> tx_valid && left_q == $past(lb.count))
		else $error("burst did not start with written count");
	COV_LONG: cover property (tx_last && pat_q.long_pkt);
	COV_MULTI: cover property (take && tx_last && left_q == 8'h02);
endmodule

// [verification/olic_sink.sv]
// loopback sink standing in for the link partner on the fiber path
`timescale 1ns/1ps
module olic_sink (
	input  wire logic       clk,      // system clock
	input  wire logic       tx_valid, // byte offered
	input  wire logic [7:0] tx_data,  // offered byte
	input  wire logic       tx_last,  // last byte of a frame
	input  wire logic       slow,     // 1 = ready every other cycle
	output logic            tx_ready  // byte taken
);
	logic [7:0] got[$];
	int         frames = 0;
	initial
		tx_ready = 1'b0;
	// every taken byte is queued so the bench can rebuild each frame
	always @(posedge clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
		begin
			got.push_back(tx_data);
			if (tx_last === 1'b1)
				frames++;
		end
		#1 tx_ready <= slow ? !tx_ready : 1'b1;
	end
endmodule

// [verification/olic_top_tb.sv]
// self-checking bench for the loopback and init control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
	bad_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module olic_top_tb;
	logic        clk, rst_n, center_mode, tx_ready;
	logic        reg_wr = 1'b0, sink_slow = 1'b0;
	logic        rate_strap_pin = 1'b1, duplex_strap_pin = 1'b0;
	logic        autoneg_strap_pin = 1'b1, link_suppress_strap = 1'b1;
	logic        fiber_link_up = 1'b1, far_copper_link_up = 1'b1;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tx_data;
	logic [47:0] station_addr = 48'h0211_2233_4450;
	logic        copper_port_rate_sel, copper_port_duplex_sel;
	logic        copper_port_autoneg_en, fabric_soft_reset, phy_soft_reset;
	logic        remote_cmd_en, fiber_tx_oe_n, copper_tx_disable;
	logic        copper_led_off, valid_cnt_clear, result_cnt_clear;
	logic        lb_busy, tx_valid, tx_last;
	int          bad_count = 0, n_compared = 0, len = 60;
	int          n_fab = 0, n_phy = 0, n_vc = 0, n_rc = 0;
	wire  [2:0]  pbits = {copper_port_rate_sel, copper_port_duplex_sel,
		copper_port_autoneg_en};
	wire  [1:0]  sup = {copper_tx_disable, copper_led_off};
	typedef struct {
		logic [7:0] wa, wd, ra, re;
		logic [2:0] pt;
		logic       oe_n, rem;
	} olic_row_t;
	olic_row_t   rows[9] = '{
		'{8'h40, 8'h00, 8'h43, 8'hA4, 3'b101, 1'b0, 1'b0},
		'{8'h43, 8'hC8, 8'h2C, 8'h60, 3'b110, 1'b0, 1'b1},
		'{8'h2C, 8'h80, 8'h43, 8'h28, 3'b001, 1'b0, 1'b1},
		'{8'h43, 8'h02, 8'h43, 8'h02, 3'b000, 1'b1, 1'b0},
		'{8'h43, 8'h10, 8'h43, 8'h00, 3'b000, 1'b0, 1'b0},
		'{8'h45, 8'h80, 8'h45, 8'h80, 3'b000, 1'b0, 1'b0},
		'{8'h44, 8'h65, 8'h44, 8'h65, 3'b000, 1'b0, 1'b0},
		'{8'h50, 8'hFF, 8'h50, 8'h00, 3'b000, 1'b0, 1'b0},
		'{8'h2C, 8'h60, 8'h43, 8'hC0, 3'b110, 1'b0, 1'b0}
	};
	// last entry is not one-hot: it must fall back to the plain pattern
	logic [7:0]  pats[10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08,
		8'h10, 8'h20, 8'h40, 8'h80, 8'h03};

	olic_top i_dut (
		.clk, .rst_n, .center_mode, .rate_strap_pin, .duplex_strap_pin,
		.autoneg_strap_pin, .link_suppress_strap, .reg_wr, .reg_addr,
		.reg_wdata, .reg_rdata, .station_addr, .fiber_link_up,
		.far_copper_link_up, .copper_port_rate_sel,
		.copper_port_duplex_sel, .copper_port_autoneg_en,
		.fabric_soft_reset, .phy_soft_reset, .remote_cmd_en,
		.fiber_tx_oe_n, .copper_tx_disable, .copper_led_off,
		.valid_cnt_clear, .result_cnt_clear, .lb_busy, .tx_valid,
		.tx_data, .tx_last, .tx_ready
	);
	olic_sink i_sink (
		.clk, .tx_valid, .tx_data, .tx_last, .slow(sink_slow), .tx_ready
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// pulses may land on any of the three edges wr samples, from the write edge on
	task automatic smp();
		tick();
		n_fab += (fabric_soft_reset === 1'b1);
		n_phy += (phy_soft_reset === 1'b1);
		n_vc += (valid_cnt_clear === 1'b1);
		n_rc += (result_cnt_clear === 1'b1);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		smp();
		reg_wr = 1'b0;
		smp();
		smp();
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		reg_addr = a;
		tick();
		`CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic rst(logic cm);
		rst_n = 1'b0;
		center_mode = cm;
		tick(4);
		`CHK("rst_rdata", 8'h00, reg_rdata)
		`CHK("rst_busy", 1'b0, lb_busy)
		`CHK("rst_phy", 1'b0, phy_soft_reset)
		rst_n = 1'b1;
		tick(2);
	endtask
	// byte j of the burst as the pattern select and station address ask
	function automatic logic [7:0] exp_byte(logic [7:0] p, int j);
		logic [7:0]  s;
		logic [15:0] w;
		int          i;
		s = 8'(j / len + 1);
		i = j % len;
		w = p[7] ? 16'hFF00 : ((p[6:3] != 4'h0) ? 16'h0F0F : 16'h55AA);
		if (i < 6 && (p & 8'hE6) != 8'h00)
			return 8'hFF;
		if (i == 5)
			return station_addr[7:0] + s;
		if (i < 12)
			return station_addr[47 - 8 * (i % 6) -: 8];
		if (i < 14)
			return (i == 12) ? 8'h08 : 8'h00;
		return i[0] ? w[7:0] : w[15:8];
	endfunction
	task automatic burst(logic [7:0] p, logic [7:0] n, logic sl);
		logic [7:0] q;
		q = ($countones(p) > 1) ? 8'h00 : p;
		len = ((q & 8'hD5) != 8'h00) ? 1514 : 60;
		i_sink.got.delete();
		i_sink.frames = 0;
		sink_slow = sl;
		wr(8'h45, p);
		wr(8'h44, n);
		for (int k = 0; k < 40000 && lb_busy !== 1'b0; k++)
			tick();
		`CHK("busy_end", 1'b0, lb_busy)
		`CHK("frames", n, i_sink.frames)
		`CHK("bytes", n * len, i_sink.got.size())
		for (int j = 0; j < i_sink.got.size() && j < n * len; j++)
			`CHK("byte", exp_byte(q, j), i_sink.got[j])
	endtask
	task automatic done(string t);
		$display("test %s finished, mismatches so far %0d", t, bad_count);
	endtask
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#400_000;
		bad_count++;
		end_sim();
	end
	initial
	begin
		rst(1'b1);
		foreach (rows[r])
		begin
			wr(rows[r].wa, rows[r].wd);
			rd(rows[r].ra, rows[r].re);
			`CHK("port_bits", rows[r].pt, pbits)
			`CHK("fib_oe_n", rows[r].oe_n, fiber_tx_oe_n)
			`CHK("remote", rows[r].rem, remote_cmd_en)
			`CHK("idle", 1'b0, lb_busy)
		end
		done("rows");
		foreach (pats[k])
			burst(pats[k], 8'h01, 1'b0);
		done("patterns");
		burst(8'h00, 8'h64, 1'b1);
		done("count_max");
		wr(8'h45, 8'h01);
		wr(8'h44, 8'h05);
		tick(20);
		n_fab = 0;
		wr(8'h43, 8'h10);
		`CHK("fab_pulse", 1, n_fab)
		`CHK("aborted", 1'b0, lb_busy)
		rd(8'h44, 8'h07);
		rd(8'h45, 8'h00);
		done("abort");
		n_vc = 0;
		n_rc = 0;
		wr(8'h44, 8'h00);
		`CHK("vc_clr", 1, n_vc)
		`CHK("rc_clr", 1, n_rc)
		wr(8'h43, 8'h04);
		fiber_link_up = 1'b0;
		tick(3);
		`CHK("ctr_sup", 2'b00, sup)
		fiber_link_up = 1'b1;
		done("center");
		duplex_strap_pin = 1'b1;
		rst(1'b1);
		rd(8'h43, 8'hE5);
		rd(8'h44, 8'h07);
		rd(8'h45, 8'h00);
		tick(5);
		`CHK("phy_hold", 1'b1, phy_soft_reset)
		wr(8'h40, 8'h00);
		`CHK("phy_clr", 1'b0, phy_soft_reset)
		done("center_reset");
		rst(1'b0);
		rd(8'h43, 8'hE4);
		wr(8'h45, 8'h20);
		wr(8'h44, 8'h33);
		n_phy = 0;
		wr(8'h43, 8'h05);
		`CHK("phy_pulse", 1, n_phy)
		rd(8'h43, 8'h04);
		rd(8'h45, 8'h20);
		rd(8'h44, 8'h33);
		`CHK("term_idle", 1'b0, lb_busy)
		n_vc = 0;
		n_rc = 0;
		wr(8'h44, 8'h00);
		`CHK("vc_term", 1, n_vc)
		`CHK("rc_term", 0, n_rc)
		fiber_link_up = 1'b0;
		tick(3);
		`CHK("sup_fib", 2'b11, sup)
		fiber_link_up = 1'b1;
		far_copper_link_up = 1'b0;
		tick(3);
		`CHK("sup_far", 2'b11, sup)
		far_copper_link_up = 1'b1;
		tick(3);
		`CHK("sup_off", 2'b00, sup)
		done("terminal");
		end_sim();
	end
endmodule
